// ===== rtl/prhc_pkg.sv
// Purpose: Shared constants for the pager receiver host-control block
// Assumes: 10 MHz decoder clock, classic Wishbone register access
// Notes:   Packet ID sits in bits 31:24 of every packet word
package prhc_pkg;

    // Clock and time base
    localparam int CLK_HZ         = 10_000_000;
    localparam int STEP_US        = 625;
    localparam int STEP_CYC       = (CLK_HZ / 1_000_000) * STEP_US;
    localparam int UNIT_MS        = 80;
    localparam int UNIT_TICKS     = (UNIT_MS * 1000) / STEP_US;
    localparam int IDLE_DEF_MS    = 1500;
    localparam int IDLE_DEF_TICKS = (IDLE_DEF_MS * 1000) / STEP_US;
    localparam int SRCH_SHORT_S   = 60;
    localparam int SRCH_LONG_S    = 240;
    localparam int SRCH_SHORT_TK  = (SRCH_SHORT_S * 1_000_000) / STEP_US;
    localparam int SRCH_LONG_TK   = (SRCH_LONG_S * 1_000_000) / STEP_US;
    localparam int TICK_W         = 19;

    // Packet identifiers
    localparam logic [7:0] ID_ROAM    = 8'h05;
    localparam logic [7:0] ID_TIMING  = 8'h06;
    localparam logic [7:0] ID_LINECTL = 8'h0F;
    localparam logic [7:0] ID_SET_LO  = 8'h10;
    localparam logic [7:0] ID_SET_HI  = 8'h1B;
    localparam int         NUM_SET    = 12;
    localparam logic [2:0] WARM_FIRST = 3'h1;
    localparam logic [2:0] WARM_LAST  = 3'h5;

    // Packet field positions
    localparam int ID_LSB          = 24;
    localparam int B2_LSB          = 16;
    localparam int B1_LSB          = 8;
    localparam int B0_LSB          = 0;
    localparam int ROAM_NOSRCH_BIT = 12;
    localparam int ROAM_NDREQ_BIT  = 17;
    localparam int ROAM_MFP_LSB    = 4;
    localparam int ROAM_CARRY_LSB  = 0;
    localparam int SET_VALID_BIT   = 23;
    localparam int SET_PROBE_BIT   = 19;

    // Reset values
    localparam logic [7:0] RST_DUR = 8'h01;

    // Missed-frame policy codes and frame limits
    localparam logic [1:0] MFP_NEVER  = 2'h0;
    localparam logic [1:0] MFP_UPTO3  = 2'h1;
    localparam logic [1:0] MFP_UPTO7  = 2'h2;
    localparam logic [6:0] FRAME_LIM3 = 7'h03;
    localparam logic [6:0] FRAME_LIM7 = 7'h07;

    // Register byte offsets and control register bit positions
    localparam logic [3:0] ADR_PACKET = 4'h0;
    localparam logic [3:0] ADR_CTRL   = 4'h4;
    localparam logic [3:0] ADR_STATUS = 4'h8;
    localparam logic [3:0] ADR_TIMING = 4'hC;
    localparam int         CTRL_ON    = 0;
    localparam int         CTRL_SHORT = 1;

    // Receiver sequencer states
    typedef enum logic [5:0] {
        ST_OFF    = 6'h01,
        ST_HOLD   = 6'h02,
        ST_WARM   = 6'h04,
        ST_DETECT = 6'h08,
        ST_SEARCH = 6'h10,
        ST_SPARE  = 6'h20
    } prhc_state_t;

    // Width of the step duration field per setting entry
    function automatic logic [7:0] durMask(input int idx);
        if (idx == 0) begin
            durMask = 8'hFF;
        end else if (idx <= 6) begin
            durMask = 8'h7F;
        end else if (idx >= 10) begin
            durMask = 8'h3F;
        end else begin
            durMask = 8'h00;
        end
    endfunction

endpackage

// ===== rtl/prhc_top.sv
// Purpose: Decodes host control packets and runs the receiver line sequencer
// Assumes: Host writes each packet word to the packet register, ID in top byte
// Notes:   Bytes may arrive in any lane order; a packet acts once all four are in
module prhc_top #(
    parameter int STEP_CYCLES = prhc_pkg::STEP_CYC
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [3:0]  wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatIn,
    output logic             wbAck,
    output logic      [31:0] wbDatOut,
    input  wire logic        noiseCheckDone,
    input  wire logic        signalFound,
    input  wire logic        syncFound,
    input  wire logic [6:0]  frameNum,
    input  wire logic [4:0]  missedFlagsIn,
    input  wire logic [1:0]  airCarryOn,
    input  wire logic        lowBatteryPin,
    output logic      [4:0]  missedFlagsOut,
    output logic      [1:0]  carryFollow,
    output logic             noiseCheckGo,
    output logic             searchActive,
    output logic      [7:0]  rxLineOut,
    output logic      [7:0]  rxLineOe_n
);

    // Bus and packet assembly
    logic        busReq;
    logic        pktWr;
    logic [31:0] pktWord_ff;
    logic [3:0]  pktSeen_ff;
    logic        pktFull_ff;
    logic [31:0] nxt_pktWord;
    logic [3:0]  nxt_pktSeen;
    logic [7:0]  pktId;

    // Control fields
    logic        decodeOn_ff;
    logic        shortSearch_ff;
    logic        noSearch_ff;
    logic        hostReq_ff;
    logic [1:0]  missPolicy_ff;
    logic [1:0]  carryLimit_ff;
    logic [7:0]  searchLen_ff;
    logic [7:0]  idleLen_ff;
    logic [7:0]  overrideMask_ff;
    logic [7:0]  forcedVal_ff;

    // Setting entries
    logic [7:0]  setLine_ff  [prhc_pkg::NUM_SET];
    logic [7:0]  setDur_ff   [prhc_pkg::NUM_SET];
    logic        setProbe_ff [prhc_pkg::NUM_SET];
    logic        setValid_ff [prhc_pkg::NUM_SET];

    // Sequencer
    prhc_pkg::prhc_state_t   state_ff;
    prhc_pkg::prhc_state_t   nxt_state;
    logic [2:0]              stepIdx_ff;
    logic [2:0]              nxt_stepIdx;
    logic [12:0]             preCnt_ff;
    logic                    tick_ff;
    logic [7:0]              stepCnt_ff;
    logic [prhc_pkg::TICK_W-1:0] idleCnt_ff;
    logic [prhc_pkg::TICK_W-1:0] srchCnt_ff;
    logic [prhc_pkg::TICK_W-1:0] idleTicks;
    logic [prhc_pkg::TICK_W-1:0] srchTicks;
    logic                    autoDue_ff;
    logic                    stepDone;
    logic                    detectStart;
    logic                    curProbe;
    logic [7:0]              curDur;
    logic [7:0]              curLine;
    logic                    lowBatSync1_ff;
    logic                    lowBatSync2_ff;
    logic                    lowBattery_ff;
    logic                    allowMiss;

    assign busReq = wbCyc & wbStb & ~wbAck;
    assign pktWr  = busReq & wbWe & (wbAdr == prhc_pkg::ADR_PACKET);
    assign pktId  = pktWord_ff[prhc_pkg::ID_LSB +: 8];

    // Merge byte lanes of a packet write into the assembly word
    always_comb begin
        nxt_pktWord = pktWord_ff;
        nxt_pktSeen = pktFull_ff ? 4'h0 : pktSeen_ff;
        for (int b = 0; b < 4; b++) begin
            if (pktWr && wbSel[b]) begin
                nxt_pktWord[b*8 +: 8] = wbDatIn[b*8 +: 8];
                nxt_pktSeen[b]        = 1'b1;
            end
        end
    end

    // Packet is handed on only once every byte has arrived
    always_ff @(posedge clock) begin
        if (rst) begin
            pktWord_ff <= 32'h0000_0000;
            pktSeen_ff <= 4'h0;
            pktFull_ff <= 1'b0;
        end else begin
            pktWord_ff <= nxt_pktWord;
            pktSeen_ff <= nxt_pktSeen;
            pktFull_ff <= (nxt_pktSeen == 4'hF);
        end
    end

    // Wishbone answer: one-cycle ack, unmapped reads return zero
    always_ff @(posedge clock) begin
        if (rst) begin
            wbAck    <= 1'b0;
            wbDatOut <= 32'h0000_0000;
        end else begin
            wbAck    <= busReq;
            wbDatOut <= 32'h0000_0000;
            if (busReq && !wbWe) begin
                case (wbAdr)
                    prhc_pkg::ADR_CTRL: begin
                        wbDatOut <= {30'h0000_0000, shortSearch_ff, decodeOn_ff};
                    end
                    prhc_pkg::ADR_STATUS: begin
                        wbDatOut <= {13'h0000, stepIdx_ff, 2'h0, state_ff,
                                     pktSeen_ff, 1'b0, hostReq_ff, searchActive,
                                     lowBattery_ff};
                    end
                    prhc_pkg::ADR_TIMING: begin
                        wbDatOut <= {overrideMask_ff, forcedVal_ff, searchLen_ff,
                                     idleLen_ff};
                    end
                    default: begin
                        wbDatOut <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // Control register written directly over the bus
    always_ff @(posedge clock) begin
        if (rst) begin
            decodeOn_ff    <= 1'b0;
            shortSearch_ff <= 1'b0;
        end else if (busReq && wbWe && wbAdr == prhc_pkg::ADR_CTRL && wbSel[0]) begin
            decodeOn_ff    <= wbDatIn[prhc_pkg::CTRL_ON];
            shortSearch_ff <= wbDatIn[prhc_pkg::CTRL_SHORT];
        end
    end

    // Roaming, timing and line-control packets; other IDs fall through
    always_ff @(posedge clock) begin
        if (rst) begin
            noSearch_ff     <= 1'b0;
            missPolicy_ff   <= 2'h0;
            carryLimit_ff   <= 2'h0;
            searchLen_ff    <= 8'h00;
            idleLen_ff      <= 8'h00;
            overrideMask_ff <= 8'h00;
            forcedVal_ff    <= 8'h00;
        end else if (pktFull_ff) begin
            case (pktId)
                prhc_pkg::ID_ROAM: begin
                    noSearch_ff   <= pktWord_ff[prhc_pkg::ROAM_NOSRCH_BIT];
                    missPolicy_ff <= pktWord_ff[prhc_pkg::ROAM_MFP_LSB +: 2];
                    carryLimit_ff <= pktWord_ff[prhc_pkg::ROAM_CARRY_LSB +: 2];
                end
                prhc_pkg::ID_TIMING: begin
                    searchLen_ff <= pktWord_ff[prhc_pkg::B1_LSB +: 8];
                    idleLen_ff   <= pktWord_ff[prhc_pkg::B0_LSB +: 8];
                end
                prhc_pkg::ID_LINECTL: begin
                    overrideMask_ff <= pktWord_ff[prhc_pkg::B1_LSB +: 8];
                    forcedVal_ff    <= pktWord_ff[prhc_pkg::B0_LSB +: 8];
                end
                default: begin
                    noSearch_ff <= noSearch_ff;
                end
            endcase
        end
    end

    // Host noise-check request; a new request beats the clear
    always_ff @(posedge clock) begin
        if (rst) begin
            hostReq_ff <= 1'b0;
        end else begin
            hostReq_ff <= (hostReq_ff & ~detectStart)
                        | (pktFull_ff && pktId == prhc_pkg::ID_ROAM
                           && pktWord_ff[prhc_pkg::ROAM_NDREQ_BIT]);
        end
    end

    // Twelve setting entries, one per ID, duration width trimmed per entry
    for (genvar i = 0; i < prhc_pkg::NUM_SET; i++) begin : gSet
        always_ff @(posedge clock) begin
            if (rst) begin
                setLine_ff[i]  <= 8'h00;
                setDur_ff[i]   <= prhc_pkg::RST_DUR;
                setProbe_ff[i] <= 1'b0;
                setValid_ff[i] <= 1'b0;
            end else if (pktFull_ff && pktId == prhc_pkg::ID_SET_LO + 8'(i)) begin
                setLine_ff[i]  <= pktWord_ff[prhc_pkg::B1_LSB +: 8];
                setDur_ff[i]   <= pktWord_ff[prhc_pkg::B0_LSB +: 8]
                                & prhc_pkg::durMask(i);
                setProbe_ff[i] <= pktWord_ff[prhc_pkg::SET_PROBE_BIT];
                setValid_ff[i] <= pktWord_ff[prhc_pkg::SET_VALID_BIT];
            end
        end
    end

    // 625 us prescaler; every timer counts these ticks for exact units
    always_ff @(posedge clock) begin
        if (rst) begin
            preCnt_ff <= 13'h0000;
            tick_ff   <= 1'b0;
        end else if (preCnt_ff == 13'(STEP_CYCLES - 1)) begin
            preCnt_ff <= 13'h0000;
            tick_ff   <= 1'b1;
        end else begin
            preCnt_ff <= preCnt_ff + 13'h0001;
            tick_ff   <= 1'b0;
        end
    end

    // Interval and search lengths in 625 us ticks
    always_comb begin
        if (idleLen_ff == 8'h00) begin
            idleTicks = prhc_pkg::TICK_W'(prhc_pkg::IDLE_DEF_TICKS);
        end else begin
            idleTicks = prhc_pkg::TICK_W'(idleLen_ff * prhc_pkg::UNIT_TICKS);
        end
        if (searchLen_ff != 8'h00) begin
            srchTicks = prhc_pkg::TICK_W'(searchLen_ff * prhc_pkg::UNIT_TICKS);
        end else if (shortSearch_ff) begin
            srchTicks = prhc_pkg::TICK_W'(prhc_pkg::SRCH_SHORT_TK);
        end else begin
            srchTicks = prhc_pkg::TICK_W'(prhc_pkg::SRCH_LONG_TK);
        end
    end

    // Entry selected by the active state
    always_comb begin
        curDur   = setDur_ff[0];
        curProbe = setProbe_ff[0];
        curLine  = setLine_ff[0];
        if (state_ff == prhc_pkg::ST_WARM || state_ff == prhc_pkg::ST_DETECT
            || state_ff == prhc_pkg::ST_SEARCH) begin
            curDur   = setDur_ff[stepIdx_ff];
            curProbe = setProbe_ff[stepIdx_ff];
            curLine  = setLine_ff[stepIdx_ff];
        end
    end

    assign stepDone    = tick_ff && (stepCnt_ff + 8'h01 >= curDur);
    assign detectStart = (nxt_state == prhc_pkg::ST_DETECT) && (state_ff != prhc_pkg::ST_DETECT);

    // Receiver sequencer
    always_comb begin
        nxt_state   = state_ff;
        nxt_stepIdx = stepIdx_ff;
        case (state_ff)
            prhc_pkg::ST_OFF: begin
                if (decodeOn_ff && (autoDue_ff || hostReq_ff)) begin
                    nxt_state = prhc_pkg::ST_HOLD;
                end
            end
            prhc_pkg::ST_HOLD: begin
                if (stepDone) begin
                    nxt_stepIdx = prhc_pkg::WARM_FIRST;
                    nxt_state   = setValid_ff[prhc_pkg::WARM_FIRST] ? prhc_pkg::ST_WARM
                                                                     : prhc_pkg::ST_DETECT;
                end
            end
            prhc_pkg::ST_WARM: begin
                if (stepDone) begin
                    if (stepIdx_ff == prhc_pkg::WARM_LAST
                        || !setValid_ff[stepIdx_ff + 3'h1]) begin
                        nxt_state = prhc_pkg::ST_DETECT;
                    end else begin
                        nxt_stepIdx = stepIdx_ff + 3'h1;
                    end
                end
            end
            prhc_pkg::ST_DETECT: begin
                if (noiseCheckDone) begin
                    if (signalFound && !noSearch_ff) begin
                        nxt_state = prhc_pkg::ST_SEARCH;
                    end else begin
                        nxt_state = prhc_pkg::ST_OFF;
                    end
                end
            end
            prhc_pkg::ST_SEARCH: begin
                if (syncFound || (tick_ff && srchCnt_ff + 1'b1 >= srchTicks)) begin
                    nxt_state = prhc_pkg::ST_OFF;
                end
            end
            default: begin
                nxt_state = prhc_pkg::ST_OFF;
            end
        endcase
        if (!decodeOn_ff) begin
            nxt_state = prhc_pkg::ST_OFF;
        end
        if (nxt_state == prhc_pkg::ST_OFF) begin
            nxt_stepIdx = 3'h0;
        end
    end

    // State, step timer and search timer
    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff     <= prhc_pkg::ST_OFF;
            stepIdx_ff   <= 3'h0;
            stepCnt_ff   <= 8'h00;
            srchCnt_ff   <= '0;
            noiseCheckGo <= 1'b0;
            searchActive <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            stepIdx_ff   <= nxt_stepIdx;
            noiseCheckGo <= detectStart;
            searchActive <= (nxt_state == prhc_pkg::ST_SEARCH);
            if (nxt_state != state_ff || nxt_stepIdx != stepIdx_ff) begin
                stepCnt_ff <= 8'h00;
            end else if (tick_ff) begin
                stepCnt_ff <= stepCnt_ff + 8'h01;
            end
            if (state_ff != prhc_pkg::ST_SEARCH) begin
                srchCnt_ff <= '0;
            end else if (tick_ff) begin
                srchCnt_ff <= srchCnt_ff + 1'b1;
            end
        end
    end

    // Automatic detect interval, measured from the last detect start to the next automatic request
    always_ff @(posedge clock) begin
        if (rst) begin
            idleCnt_ff <= '0;
            autoDue_ff <= 1'b0;
        end else if (detectStart || !decodeOn_ff) begin
            idleCnt_ff <= '0;
            autoDue_ff <= 1'b0;
        end else if (state_ff == prhc_pkg::ST_SEARCH) begin
            autoDue_ff <= 1'b0; // Search outranks noise checks
            if (tick_ff) begin
                idleCnt_ff <= idleCnt_ff + 1'b1;
            end
        end else if (tick_ff) begin
            if (idleCnt_ff + 1'b1 >= idleTicks) begin
                idleCnt_ff <= '0;
                autoDue_ff <= 1'b1;
            end else begin
                idleCnt_ff <= idleCnt_ff + 1'b1;
            end
        end
    end

    // Low-battery pin synchroniser and sample at the end of a probed hold or warm step
    always_ff @(posedge clock) begin
        if (rst) begin
            lowBatSync1_ff <= 1'b0;
            lowBatSync2_ff <= 1'b0;
            lowBattery_ff  <= 1'b0;
        end else begin
            lowBatSync1_ff <= lowBatteryPin;
            lowBatSync2_ff <= lowBatSync1_ff;
            if ((state_ff == prhc_pkg::ST_HOLD || state_ff == prhc_pkg::ST_WARM)
                && stepDone && curProbe) begin
                lowBattery_ff <= lowBatSync2_ff;
            end
        end
    end

    // Receiver lines: off in reset, per-line override otherwise
    for (genvar b = 0; b < 8; b++) begin : gLine
        always_ff @(posedge clock) begin
            if (rst) begin
                rxLineOut[b]  <= 1'b0;
                rxLineOe_n[b] <= 1'b1;
            end else begin
                rxLineOut[b]  <= overrideMask_ff[b] ? forcedVal_ff[b] : curLine[b];
                rxLineOe_n[b] <= 1'b0;
            end
        end
    end

    // Missed-frame gating by policy and frame number
    always_comb begin
        case (missPolicy_ff)
            prhc_pkg::MFP_NEVER: allowMiss = 1'b0;
            prhc_pkg::MFP_UPTO3: allowMiss = (frameNum <= prhc_pkg::FRAME_LIM3);
            prhc_pkg::MFP_UPTO7: allowMiss = (frameNum <= prhc_pkg::FRAME_LIM7);
            default:             allowMiss = 1'b1;
        endcase
    end

    // Reported flags and carry-on limit
    always_ff @(posedge clock) begin
        if (rst) begin
            missedFlagsOut <= 5'h00;
            carryFollow    <= 2'h0;
        end else begin
            missedFlagsOut <= missedFlagsIn & {5{allowMiss}};
            carryFollow    <= (airCarryOn < carryLimit_ff) ? airCarryOn : carryLimit_ff;
        end
    end

endmodule

// ===== bench/prhc_checker.sv
// Purpose: Port-level checks on prhc_top
// Assumes: One clock, rst synchronous active high
// Notes:   Attached by the bind at the foot of this file
module prhc_checker (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        wbCyc,
    input wire logic        wbStb,
    input wire logic        wbAck,
    input wire logic [31:0] wbDatOut,
    input wire logic [4:0]  missedFlagsIn,
    input wire logic [1:0]  airCarryOn,
    input wire logic [4:0]  missedFlagsOut,
    input wire logic [1:0]  carryFollow,
    input wire logic        noiseCheckGo,
    input wire logic [7:0]  rxLineOe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Bus handshake: answer one cycle after a request, pulse only
    a_ack_answer: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
        else $error("request not answered in one cycle");
    a_ack_pulse: assert property (wbAck |=> !wbAck)
        else $error("ack held longer than one cycle");
    a_rdata_idle: assert property (!wbAck |-> wbDatOut == 32'h0)
        else $error("read data not zero outside ack");
    // Reset must float lines regardless of the default disable
    a_oe_reset: assert property (disable iff (1'b0) rst |=> rxLineOe_n == 8'hFF)
        else $error("lines driven during reset");
    a_oe_run: assert property (!rst |=> rxLineOe_n == 8'h00)
        else $error("lines not driven outside reset");
    a_go_pulse: assert property (noiseCheckGo |=> !noiseCheckGo)
        else $error("noise check start longer than a pulse");
    // Gating may only remove what came in, never invent it
    a_carry_min: assert property (1'b1 |=> carryFollow <= $past(airCarryOn))
        else $error("carry follow above received value");
    a_missed_gate: assert property (1'b1 |=> (missedFlagsOut & ~$past(missedFlagsIn)) == 5'h0)
        else $error("missed flag reported without cause");
endmodule

bind prhc_top prhc_checker prhc_checker_i (
    .clock(clock), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck),
    .wbDatOut(wbDatOut), .missedFlagsIn(missedFlagsIn), .airCarryOn(airCarryOn),
    .missedFlagsOut(missedFlagsOut), .carryFollow(carryFollow),
    .noiseCheckGo(noiseCheckGo), .rxLineOe_n(rxLineOe_n));

// ===== bench/prhc_noise_model.sv
// Purpose: Behavioural noise detector answering each check start
// Assumes: Same clock as the block
// Notes:   Found is only valid with done; it toggles during the wait
module prhc_noise_model (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic noiseCheckGo,
    input  wire logic foundCfg,
    output logic      noiseCheckDone,
    output logic      signalFound
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] waitCnt_ff;
    // Count down from each start; a new start restarts the wait
    always_ff @(posedge clock) begin
        if (rst || noiseCheckGo) begin
            waitCnt_ff <= noiseCheckGo ? 3'h5 : 3'h0;
        end else if (waitCnt_ff != 3'h0) begin
            waitCnt_ff <= waitCnt_ff - 3'h1;
        end
    end
    // Stale found value is never held, so a late sample shows up
    assign noiseCheckDone = (waitCnt_ff == 3'h1);
    assign signalFound    = noiseCheckDone ? foundCfg : waitCnt_ff[0];
endmodule

// ===== bench/pager_rx_host_control_tb_top.sv
// Purpose: Self-checking bench for prhc_top
// Assumes: Step prescaler shortened to 4 clocks
// Notes:   Detector side is a behavioural model
module pager_rx_host_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SC = 4;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        wbCyc = 1'b0;
    logic        wbStb = 1'b0;
    logic        wbWe = 1'b0;
    logic [3:0]  wbAdr = 4'h0;
    logic [3:0]  wbSel = 4'h0;
    logic [31:0] wbDatIn = 32'h0;
    logic [6:0]  frameNum = 7'h0;
    logic [1:0]  airCarryOn = 2'h3;
    logic        lowBatteryPin = 1'b0;
    logic [4:0]  missedIn = 5'h1F;
    logic        wbAck, noiseCheckDone, signalFound, noiseCheckGo, searchActive;
    logic [31:0] wbDatOut, rd;
    logic [4:0]  missedFlagsOut;
    logic [1:0]  carryFollow;
    logic [7:0]  rxLineOut, rxLineOe_n;
    int          fails = 0;
    int          cmpCount = 0;
    int          cycles = 0;
    int          n;

    prhc_top #(.STEP_CYCLES(SC)) prhc_top_i (
        .clock(clock), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbAck(wbAck),
        .wbDatOut(wbDatOut), .noiseCheckDone(noiseCheckDone), .signalFound(signalFound),
        .syncFound(1'b0), .frameNum(frameNum), .missedFlagsIn(missedIn),
        .airCarryOn(airCarryOn), .lowBatteryPin(lowBatteryPin),
        .missedFlagsOut(missedFlagsOut), .carryFollow(carryFollow),
        .noiseCheckGo(noiseCheckGo), .searchActive(searchActive),
        .rxLineOut(rxLineOut), .rxLineOe_n(rxLineOe_n));
    prhc_noise_model prhc_noise_model_i (
        .clock(clock), .rst(rst), .noiseCheckGo(noiseCheckGo), .foundCfg(1'b1),
        .noiseCheckDone(noiseCheckDone), .signalFound(signalFound));

    // 10 MHz clock and a hang guard well above the expected run
    always #50 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One classic cycle; read data taken at the ack edge only
    task automatic xfer(input logic we, input logic [3:0] a, input logic [3:0] s,
                        input logic [31:0] d);
        @(posedge clock);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbSel <= s;
        wbDatIn <= d;
        do @(posedge clock); while (wbAck !== 1'b1);
        rd = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask
    // Packets act one edge after the ack rises; wait a little beyond
    task automatic pkt(input logic [31:0] d);
        xfer(1'b1, prhc_pkg::ADR_PACKET, 4'hF, d);
        repeat (4) @(posedge clock);
    endtask
    task automatic t_timing;
        xfer(1'b1, prhc_pkg::ADR_PACKET, 4'h8, 32'h06000000);
        repeat (4) @(posedge clock);
        xfer(1'b0, prhc_pkg::ADR_TIMING, 4'hF, 32'h0);
        check("partial", rd, 32'h0);
        xfer(1'b1, prhc_pkg::ADR_PACKET, 4'h7, 32'h000001FF);
        repeat (4) @(posedge clock);
        pkt(32'h07005555);
        xfer(1'b0, prhc_pkg::ADR_TIMING, 4'hF, 32'h0);
        check("timing", rd, 32'h000001FF);
        pkt(32'h0F00F0A5);
        check("forced", {24'h0, rxLineOut}, 32'hA0);
        xfer(1'b0, prhc_pkg::ADR_TIMING, 4'hF, 32'h0);
        check("linectl", rd, 32'hF0A501FF);
        pkt(32'h0F000000);
    endtask
    task automatic t_policy;
        logic [6:0] fr[3] = '{7'h03, 7'h04, 7'h08};
        logic [31:0] want;
        for (int p = 0; p < 4; p++) begin
            pkt({24'h050000, 2'h0, p[1:0], 4'h1});
            foreach (fr[i]) begin
                frameNum <= fr[i];
                missedIn <= 5'h1F ^ fr[i][4:0];
                repeat (3) @(posedge clock);
                want = 32'h0;
                if (p == 3 || (p == 1 && fr[i] <= 3) || (p == 2 && fr[i] <= 7)) begin
                    want = {27'h0, 5'h1F ^ fr[i][4:0]};
                end
                check("missed", {27'h0, missedFlagsOut}, want);
            end
        end
        check("carry", {30'h0, carryFollow}, 32'h1);
        airCarryOn <= 2'h0;
        repeat (3) @(posedge clock);
        check("carry", {30'h0, carryFollow}, 32'h0);
    endtask
    // Entries written before decoding starts; entry 2 disabled
    task automatic t_seq;
        pkt(32'h10001102);
        pkt(32'h11882203);
        pkt(32'h12003301);
        check("offline", {24'h0, rxLineOut}, 32'h11);
        lowBatteryPin <= 1'b1;
        xfer(1'b1, prhc_pkg::ADR_CTRL, 4'hF, 32'h1);
        pkt(32'h05020000);
        for (n = 0; rxLineOut !== 8'h22 && n < 200; n++) @(posedge clock);
        check("warmline", {24'h0, rxLineOut}, 32'h22);
        for (n = 0; noiseCheckGo !== 1'b1 && n < 100; n++) @(posedge clock);
        check("warmlen", (n >= 8 && n <= 13), 32'h1);
        for (n = 0; searchActive !== 1'b1 && n < 50; n++) @(posedge clock);
        check("search", {31'h0, searchActive}, 32'h1);
        check("srchline", {24'h0, rxLineOut}, 32'h22);
        for (n = 0; searchActive === 1'b1 && n < 2000; n++) @(posedge clock);
        check("srchlen", (n >= 506 && n <= 518), 32'h1);
        xfer(1'b0, prhc_pkg::ADR_STATUS, 4'hF, 32'h0);
        check("lowbat", {31'h0, rd[0]}, 32'h1);
        pkt(32'h05021000);
        for (n = 0; noiseCheckGo !== 1'b1 && n < 300; n++) @(posedge clock);
        check("detect", {31'h0, noiseCheckGo}, 32'h1);
        n = 0;
        repeat (30) begin
            @(posedge clock);
            if (searchActive !== 1'b0) n++;
        end
        check("nosearch", n, 32'h0);
    endtask

    task automatic give_verdict;
        if (fails == 0 && cmpCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Reset, then each scenario in turn
    initial begin
        repeat (12) @(posedge clock);
        check("oereset", {24'h0, rxLineOe_n}, 32'hFF);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        check("oerun", {24'h0, rxLineOe_n}, 32'h0);
        xfer(1'b0, prhc_pkg::ADR_TIMING, 4'hF, 32'h0);
        check("rsttiming", rd, 32'h0);
        xfer(1'b0, 4'h1, 4'hF, 32'h0);
        check("unmapped", rd, 32'h0);
        t_timing();
        t_policy();
        t_seq();
        give_verdict();
    end
endmodule
